/* File: tla_pkg.sv */
// package: register map, reset values and carriers of the thermal limit alarm bank
package tla_pkg;
  // ==========================================================
  // register offsets (printed offsets are not multiples of four: indices)
  localparam logic [7:0] TLA_IDX_R3_HI_INT = 8'h26;
  localparam logic [7:0] TLA_IDX_R3_HI_FRAC = 8'h27;
  localparam logic [7:0] TLA_IDX_LO_INT = 8'h30;
  localparam logic [7:0] TLA_IDX_LO_FRAC = 8'h31;
  localparam logic [7:0] TLA_IDX_HI_FLAGS = 8'h32;
  localparam logic [7:0] TLA_IDX_LO_FLAGS = 8'h33;
  localparam logic [7:0] TLA_IDX_PIN_MASK = 8'h34;
  localparam logic [7:0] TLA_IDX_CH_HI_BASE = 8'h50;
  localparam logic [7:0] TLA_IDX_IRQ_STAT = 8'h60;
  localparam logic [7:0] TLA_IDX_IRQ_CLR = 8'h61;
  localparam logic [7:0] TLA_IDX_IRQ_EN = 8'h62;
  localparam logic [7:0] TLA_IDX_FMT = 8'h63;
  localparam int TLA_ADDR_W = 10;
  // ==========================================================
  // reset values
  localparam logic [7:0] TLA_RST_R3_HI_INT = 8'h7F;
  localparam logic [7:0] TLA_RST_R3_HI_FRAC = 8'h00;
  localparam logic [7:0] TLA_RST_LO_INT = 8'hC9;
  localparam logic [7:0] TLA_RST_LO_FRAC = 8'h00;
  localparam logic [3:0] TLA_RST_FLAGS = 4'h0;
  localparam logic [3:0] TLA_RST_MASK = 4'h0;
  localparam logic [15:0] TLA_RST_CH_HI = 16'h7F00;
  // ==========================================================
  // field layout
  localparam int TLA_NCH = 4;
  localparam int TLA_CH_R3 = 3;
  localparam logic [3:0] TLA_FRAC_ZERO = 4'h0;
  localparam logic [1:0] TLA_RESP_OKAY = 2'b00;
  localparam logic [1:0] TLA_RESP_SLVERR = 2'b10;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic valid;
    logic [TLA_NCH-1:0][15:0] temp;
  } tla_meas_s;
  typedef struct packed {
    logic [3:0] hi;
    logic [3:0] lo;
  } tla_flags_s;
endpackage : tla_pkg

/* File: tla_thermal_limit_alarm_regs.sv */
// thermal limit alarm register bank with AXI4-Lite slave
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Functional notes
// - shared low limit integer byte, reset C9h
// - shared low limit fraction byte, reset 00h
// - remote 3 high limit fraction, reset 00h
// - high flag when channel exceeds own limit
// - low flag when channel below shared limit
// - flag registers read-only, reset 00h
// - mask bit suppresses alarm pin per channel
// - remote 3 high limit integer, reset 7Fh
module tla_thermal_limit_alarm_regs
  import tla_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [TLA_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [TLA_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire tla_pkg::tla_meas_s meas,
  output logic over_temp_alarm_pin_o,
  output logic over_temp_alarm_pin_oe,
  output logic irq
);
  import tla_pkg::*;

  // ==========================================================
  // state
  logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic arready_r, arready_nxt;
  logic [TLA_ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [7:0] r3_hi_int_r, r3_hi_int_nxt, r3_hi_frac_r, r3_hi_frac_nxt;
  logic [7:0] lo_int_r, lo_int_nxt, lo_frac_r, lo_frac_nxt;
  logic [2:0][15:0] ch_hi_r, ch_hi_nxt;
  tla_flags_s flags_r, flags_nxt;
  logic [3:0] mask_r, mask_nxt;
  logic [7:0] ist_r, ist_nxt, ien_r, ien_nxt;
  logic fmt_r, fmt_nxt;
  logic pin_r, pin_nxt, irq_r, irq_nxt;
  logic [TLA_NCH-1:0] hi_hit, lo_hit;
  logic [TLA_NCH-1:0][15:0] hi_lim;
  logic [7:0] widx, ridx, wb;
  logic wr_go, wr_ok, rd_go;
  logic [7:0] ist_set, ist_clr;

  // ==========================================================
  // comparators
  assign hi_lim[0] = ch_hi_r[0];
  assign hi_lim[1] = ch_hi_r[1];
  assign hi_lim[2] = ch_hi_r[2];
  assign hi_lim[TLA_CH_R3] = {r3_hi_int_r, r3_hi_frac_r};
  genvar g;
  generate
    for (g = 0; g < TLA_NCH; g++) begin : g_cmp
      assign hi_hit[g] = meas.valid &&
        ($signed(meas.temp[g]) > $signed(hi_lim[g]));
      assign lo_hit[g] = meas.valid &&
        ($signed(meas.temp[g]) < $signed({lo_int_r, lo_frac_r}));
    end
  endgenerate

  // ==========================================================
  // bus decode
  assign widx = awaddr_r[TLA_ADDR_W-1:2];
  assign wb = wdata_r[7:0];
  assign wr_go = aw_got_r && w_got_r && !bvalid_r;
  assign wr_ok = wstrb_r[0];
  assign rd_go = s_axi_arvalid && !rvalid_r;
  assign ridx = s_axi_araddr[TLA_ADDR_W-1:2];

  always_comb begin
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    r3_hi_int_nxt = r3_hi_int_r;
    r3_hi_frac_nxt = r3_hi_frac_r;
    lo_int_nxt = lo_int_r;
    lo_frac_nxt = lo_frac_r;
    ch_hi_nxt = ch_hi_r;
    mask_nxt = mask_r;
    ien_nxt = ien_r;
    fmt_nxt = fmt_r;
    ist_clr = 8'h00;
    if (s_axi_awvalid && !aw_got_r) begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_got_r) begin
      w_got_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (wr_go) begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = TLA_RESP_OKAY;
      // stored bytes are never rewritten on a format change
      case (widx)
        TLA_IDX_R3_HI_INT: begin
          if (wr_ok) r3_hi_int_nxt = wb;
        end
        TLA_IDX_R3_HI_FRAC: begin
          if (wr_ok) r3_hi_frac_nxt = {wb[7:4], TLA_FRAC_ZERO};
        end
        TLA_IDX_LO_INT: begin
          if (wr_ok) lo_int_nxt = wb;
        end
        TLA_IDX_LO_FRAC: begin
          if (wr_ok) lo_frac_nxt = {wb[7:4], TLA_FRAC_ZERO};
        end
        TLA_IDX_HI_FLAGS, TLA_IDX_LO_FLAGS, TLA_IDX_IRQ_STAT: begin
          // read-only: write accepted and ignored
        end
        TLA_IDX_PIN_MASK: begin
          if (wr_ok) mask_nxt = wb[3:0];
        end
        TLA_IDX_CH_HI_BASE, TLA_IDX_CH_HI_BASE + 8'h01, TLA_IDX_CH_HI_BASE + 8'h02: begin
          if (wstrb_r[1]) ch_hi_nxt[widx[1:0]][15:8] = wdata_r[15:8];
          if (wr_ok) ch_hi_nxt[widx[1:0]][7:0] = {wb[7:4], TLA_FRAC_ZERO};
        end
        TLA_IDX_IRQ_CLR: begin
          if (wr_ok) ist_clr = wb;
        end
        TLA_IDX_IRQ_EN: begin
          if (wr_ok) ien_nxt = wb;
        end
        TLA_IDX_FMT: begin
          if (wr_ok) fmt_nxt = wb[0];
        end
        default: begin
          bresp_nxt = TLA_RESP_SLVERR;
        end
      endcase
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (rd_go) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = TLA_RESP_OKAY;
      case (ridx)
        TLA_IDX_R3_HI_INT: begin
          rdata_nxt = {24'h000000, r3_hi_int_r};
        end
        TLA_IDX_R3_HI_FRAC: begin
          rdata_nxt = {24'h000000, r3_hi_frac_r};
        end
        TLA_IDX_LO_INT: begin
          rdata_nxt = {24'h000000, lo_int_r};
        end
        TLA_IDX_LO_FRAC: begin
          rdata_nxt = {24'h000000, lo_frac_r};
        end
        TLA_IDX_HI_FLAGS: begin
          rdata_nxt = {28'h0000000, flags_r.hi};
        end
        TLA_IDX_LO_FLAGS: begin
          rdata_nxt = {28'h0000000, flags_r.lo};
        end
        TLA_IDX_PIN_MASK: begin
          rdata_nxt = {28'h0000000, mask_r};
        end
        TLA_IDX_CH_HI_BASE, TLA_IDX_CH_HI_BASE + 8'h01, TLA_IDX_CH_HI_BASE + 8'h02:
          rdata_nxt = {16'h0000, ch_hi_r[ridx[1:0]]};
        TLA_IDX_IRQ_STAT: begin
          rdata_nxt = {24'h000000, ist_r};
        end
        TLA_IDX_IRQ_CLR: begin
          rdata_nxt = 32'h00000000;
        end
        TLA_IDX_IRQ_EN: begin
          rdata_nxt = {24'h000000, ien_r};
        end
        TLA_IDX_FMT: begin
          rdata_nxt = {31'h00000000, fmt_r};
        end
        default: begin
          rdata_nxt = 32'h00000000;
          rresp_nxt = TLA_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    // ready outputs registered from the next holding state
    awready_nxt = !aw_got_nxt;
    wready_nxt = !w_got_nxt;
    arready_nxt = !rvalid_nxt;
  end

  // ==========================================================
  // flags, alarm pin and interrupt
  always_comb begin
    flags_nxt = flags_r;
    if (meas.valid) begin
      flags_nxt.hi = hi_hit;
      flags_nxt.lo = lo_hit;
    end
    pin_nxt = |((flags_nxt.hi | flags_nxt.lo) & ~mask_r);
    ist_set = {(hi_hit & ~flags_r.hi), (lo_hit & ~flags_r.lo)} & {8{meas.valid}};
    ist_nxt = (ist_r & ~ist_clr) | ist_set;
    irq_nxt = |(ist_nxt & ien_nxt);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      arready_r <= 1'b1;
      awaddr_r <= '0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= TLA_RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= TLA_RESP_OKAY;
      rdata_r <= 32'h00000000;
      r3_hi_int_r <= TLA_RST_R3_HI_INT;
      r3_hi_frac_r <= TLA_RST_R3_HI_FRAC;
      lo_int_r <= TLA_RST_LO_INT;
      lo_frac_r <= TLA_RST_LO_FRAC;
      ch_hi_r <= {3{TLA_RST_CH_HI}};
      flags_r <= {TLA_RST_FLAGS, TLA_RST_FLAGS};
      mask_r <= TLA_RST_MASK;
      ist_r <= 8'h00;
      ien_r <= 8'h00;
      fmt_r <= 1'b0;
      pin_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      arready_r <= arready_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      r3_hi_int_r <= r3_hi_int_nxt;
      r3_hi_frac_r <= r3_hi_frac_nxt;
      lo_int_r <= lo_int_nxt;
      lo_frac_r <= lo_frac_nxt;
      ch_hi_r <= ch_hi_nxt;
      flags_r <= flags_nxt;
      mask_r <= mask_nxt;
      ist_r <= ist_nxt;
      ien_r <= ien_nxt;
      fmt_r <= fmt_nxt;
      pin_r <= pin_nxt;
      irq_r <= irq_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign over_temp_alarm_pin_o = 1'b0;
  assign over_temp_alarm_pin_oe = pin_r;
  assign irq = irq_r;
endmodule : tla_thermal_limit_alarm_regs
`default_nettype wire

/* File: tla_meas_src.sv */
// model: measurement source feeding the alarm bank
`timescale 1ns/1ps
`default_nettype none
module tla_meas_src
  import tla_pkg::*;
(
  input wire logic aclk,
  input wire logic go,
  input wire logic [63:0] t,
  output var tla_pkg::tla_meas_s meas
);
  import tla_pkg::*;
  // ==========
  // one-cycle sample pulse; stale data is scrambled between samples
  initial meas = '0;
  always @(posedge aclk) begin
    meas.valid <= go;
    meas.temp <= go ? t : ~t;
  end
endmodule : tla_meas_src
`default_nettype wire

/* File: tla_chk_properties.sv */
// checker: bus and alarm timing of the alarm bank
`timescale 1ns/1ps
`default_nettype none
module tla_chk
  import tla_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire tla_pkg::tla_meas_s meas,
  input wire logic over_temp_alarm_pin_o,
  input wire logic over_temp_alarm_pin_oe,
  input wire logic irq
);
  import tla_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ==========
  // properties
  property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_rd_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
  property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
  property p_wr_lat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  property p_slverr; s_axi_rvalid && s_axi_rresp == TLA_RESP_SLVERR |-> s_axi_rdata == 32'h0; endproperty
  a_slverr: assert property (p_slverr) else $error("error read not zero");
  property p_pin_low; over_temp_alarm_pin_o == 1'b0; endproperty
  a_pin_low: assert property (p_pin_low) else $error("pin driven high");
  property p_oe_cause; $changed(over_temp_alarm_pin_oe) |-> $past(meas.valid) || $past(meas.valid, 2) || s_axi_bvalid || $past(s_axi_bvalid); endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("pin moved without cause");
  property p_irq_cause; $rose(irq) |-> $past(meas.valid) || $past(meas.valid, 2) || $rose(s_axi_bvalid) || $past(s_axi_bvalid); endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
  c_irq: cover property (irq);
  c_pin: cover property ($rose(over_temp_alarm_pin_oe));
  c_err: cover property (s_axi_rvalid && s_axi_rresp == TLA_RESP_SLVERR);
endmodule : tla_chk
bind tla_thermal_limit_alarm_regs tla_chk chk_u (.*);
`default_nettype wire

/* File: tla_thermal_limit_alarm_regs_test.sv */
// testbench: registers, flags, pin and interrupt of the alarm bank
`timescale 1ns/1ps
`default_nettype none
module tla_thermal_limit_alarm_regs_test;
  import tla_pkg::*;
  // ==========
  // signals and instances
  logic aclk = 1'b0, aresetn = 1'b0, go = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [9:0] s_axi_awaddr = 10'h0, s_axi_araddr = 10'h0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [63:0] t = 64'h0, tv;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic over_temp_alarm_pin_o, over_temp_alarm_pin_oe, irq;
  logic [7:0] ix [6] = '{8'h26, 8'h27, 8'h30, 8'h31, 8'h32, 8'h34};
  logic [7:0] rv [6] = '{8'h7F, 8'h00, 8'hC9, 8'h00, 8'h00, 8'h00};
  logic [7:0] v [6];
  logic [7:0] f, pf, st;
  logic [15:0] h3;
  logic [3:0] m;
  tla_meas_s meas;
  int error_cnt = 0, n_tests = 0;
  always #5 aclk = ~aclk;
  tla_meas_src src_u (.aclk(aclk), .go(go), .t(t), .meas(meas));
  tla_thermal_limit_alarm_regs dut_u (.*);
  // ==========
  // helpers
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic hang(input int n);
    if (n == 50) begin
      error_cnt++;
      end_of_test();
    end
  endtask : hang
  task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] er = TLA_RESP_OKAY);
    int n;
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    hang(n);
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rc(input logic [7:0] i, input logic [31:0] e, input logic [1:0] er);
    int n;
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    hang(n);
    chk($sformatf("reg %h", i), s_axi_rdata, e);
    chk("resp", {30'h0, s_axi_rresp}, {30'h0, er});
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rc
  function automatic logic [31:0] exp_wr(input logic [7:0] i, input logic [7:0] d);
    case (i)
      8'h27, 8'h31: return {24'h0, d[7:4], 4'h0};
      8'h32: return 32'h0;
      8'h34: return {28'h0, d[3:0]};
      default: return {24'h0, d};
    endcase
  endfunction : exp_wr
  function automatic logic [7:0] exp_fl(input logic [63:0] x, input logic [15:0] h);
    for (int c = 0; c < 4; c++) begin
      exp_fl[4 + c] = $signed(x[16*c+:16]) > $signed(c == 3 ? h : TLA_RST_CH_HI);
      exp_fl[c] = $signed(x[16*c+:16]) < $signed({TLA_RST_LO_INT, TLA_RST_LO_FRAC});
    end
  endfunction : exp_fl
  // ==========
  // main sequence
  initial begin
    void'($urandom(32'hE25E));
    pf = 8'h00;
    st = 8'h00;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (ix[k]) rc(ix[k], {24'h0, rv[k]}, TLA_RESP_OKAY);
    rc(8'h33, 32'h0, TLA_RESP_OKAY);
    foreach (ix[k]) begin
      v[k] = 8'($urandom);
      wr(ix[k], v[k]);
      rc(ix[k], exp_wr(ix[k], v[k]), TLA_RESP_OKAY);
    end
    wr(8'h63, 8'h01);
    foreach (ix[k]) rc(ix[k], exp_wr(ix[k], v[k]), TLA_RESP_OKAY);
    rc(8'h40, 32'h0, TLA_RESP_SLVERR);
    wr(8'h40, 8'h55, TLA_RESP_SLVERR);
    $display("test registers done");
    wr(8'h30, TLA_RST_LO_INT);
    wr(8'h31, TLA_RST_LO_FRAC);
    for (int k = 0; k < 6; k++) begin
      h3 = {1'b0, 11'($urandom), 4'h0};
      m = (k == 0) ? 4'h0 : (k == 1) ? 4'h9 : 4'($urandom);
      wr(8'h26, h3[15:8]);
      wr(8'h27, h3[7:0]);
      wr(8'h34, {4'h0, m});
      tv = {h3 + 16'h1, 16'h7F00, 16'($urandom), 16'hC8FF};
      f = exp_fl(tv, h3);
      st = st | (f & ~pf);
      pf = f;
      t <= tv;
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      repeat (3) @(posedge aclk);
      rc(8'h32, {28'h0, f[7:4]}, TLA_RESP_OKAY);
      rc(8'h33, {28'h0, f[3:0]}, TLA_RESP_OKAY);
      chk("pin", {31'h0, over_temp_alarm_pin_oe}, {31'h0, |((f[7:4] | f[3:0]) & ~m)});
    end
    $display("test flags done");
    chk("irq", {31'h0, irq}, 32'h0);
    rc(8'h60, {24'h0, st}, TLA_RESP_OKAY);
    wr(8'h62, 8'hFF);
    chk("irq", {31'h0, irq}, {31'h0, |st});
    wr(8'h61, st);
    chk("irq", {31'h0, irq}, 32'h0);
    rc(8'h60, 32'h0, TLA_RESP_OKAY);
    $display("test interrupt done");
    end_of_test();
  end
endmodule : tla_thermal_limit_alarm_regs_test
`default_nettype wire
